// ---- design/ssim_map.vh ----
// register map and field layout of the serial sync interrupt mask block
`ifndef SSIM_MAP_VH
`define SSIM_MAP_VH
`define SSIM_ADDR_W 8
`define SSIM_WORD_LSB 2
`define SSIM_LANE0 0
`define SSIM_LANE1 1
`define SSIM_LANE0_W 8
`define SSIM_LANE1_W 4
`define SSIM_OFF_STATUS 8'h00
`define SSIM_OFF_ENABLE 8'h04
`define SSIM_OFF_DISABLE 8'h08
`define SSIM_OFF_MASK 8'h0C
`define SSIM_OFF_IRQ_STAT 8'h10
`define SSIM_OFF_IRQ_MASK 8'h14
`define SSIM_NSRC 12
`define SSIM_SRC_MSB 11
`define SSIM_B_TX_HOLDING_FREE 0
`define SSIM_B_TX_ALL_SENT 1
`define SSIM_B_TX_TRANSFER_END 2
`define SSIM_B_TX_BUFFERS_EXHAUSTED 3
`define SSIM_B_RX_WORD_AVAILABLE 4
`define SSIM_B_RX_OVERRUN 5
`define SSIM_B_RX_TRANSFER_END 6
`define SSIM_B_RX_BUFFERS_EXHAUSTED 7
`define SSIM_B_COMPARE_MATCH_A 8
`define SSIM_B_COMPARE_MATCH_B 9
`define SSIM_B_TX_FRAME_SYNC 10
`define SSIM_B_RX_FRAME_SYNC 11
`define SSIM_STICKY_MASK 12'hF20
`define SSIM_MASK_RESET 12'h000
`define SSIM_RSVD_W 20
`define SSIM_RESP_OKAY 2'h0
`define SSIM_RESP_SLVERR 2'h2
`endif

// ---- design/ssim_sticky.v ----
// sticky status flags, set by events and cleared by a status read
`timescale 1ns/10ps
`default_nettype none
`include "ssim_map.vh"
module ssim_sticky
(
  input wire mclk,
  input wire rst,
  input wire [`SSIM_SRC_MSB:0] set_evt,
  input wire clr,
  output reg [`SSIM_SRC_MSB:0] flag_reg
);
  reg [`SSIM_SRC_MSB:0] flag_next;
  always @*
  begin
    // set wins over a clear in the same cycle
    flag_next = (clr ? {`SSIM_NSRC{1'b0}} : flag_reg) | set_evt;
  end
  always @(posedge mclk)
  begin
    if (rst)
      flag_reg <= {`SSIM_NSRC{1'b0}};
    else
      flag_reg <= flag_next;
  end
endmodule
`default_nettype wire

// ---- design/ssim_sync2.v ----
// two flip-flop synchroniser for a vector of level inputs
`timescale 1ns/10ps
`default_nettype none
`include "ssim_map.vh"
module ssim_sync2
(
  input wire mclk,
  input wire rst,
  input wire [`SSIM_SRC_MSB:0] din,
  output reg [`SSIM_SRC_MSB:0] dout_reg
);
  reg [`SSIM_SRC_MSB:0] meta_reg;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta_reg <= {`SSIM_NSRC{1'b0}};
      dout_reg <= {`SSIM_NSRC{1'b0}};
    end
    else
    begin
      meta_reg <= din;
      dout_reg <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- design/ssim_top.v ----
// interrupt enable, disable and mask logic of the synchronous serial controller
`timescale 1ns/10ps
`default_nettype none
`include "ssim_map.vh"
module ssim_top
(
  input wire mclk,
  input wire rst,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [`SSIM_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [`SSIM_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire [`SSIM_SRC_MSB:0] src_level,
  input wire [`SSIM_SRC_MSB:0] src_pulse,
  output reg ssc_irq_reg,
  output reg ctrl_irq_reg
);

////////////////////////////////////////////////////////////////////////////////
// source conditioning

  wire [`SSIM_SRC_MSB:0] lvl_s;
  wire [`SSIM_SRC_MSB:0] pls_s;
  wire [`SSIM_SRC_MSB:0] status_flags;
  wire [`SSIM_SRC_MSB:0] ctl_flags;
  reg [`SSIM_SRC_MSB:0] pls_d_reg;
  reg [`SSIM_SRC_MSB:0] mask_reg;
  reg [`SSIM_SRC_MSB:0] mask_next;
  reg [`SSIM_SRC_MSB:0] ctl_mask_reg;
  reg [`SSIM_SRC_MSB:0] ctl_mask_next;
  reg [`SSIM_SRC_MSB:0] status_view;
  reg [`SSIM_SRC_MSB:0] sticky_set;
  reg [`SSIM_SRC_MSB:0] ctl_set;
  reg status_rd;
  reg ctl_rd;

  // source inputs come from another clock region, so both pass two flops
  ssim_sync2 u_sync_lvl
  (
    .mclk(mclk),
    .rst(rst),
    .din(src_level),
    .dout_reg(lvl_s)
  );

  ssim_sync2 u_sync_pls
  (
    .mclk(mclk),
    .rst(rst),
    .din(src_pulse),
    .dout_reg(pls_s)
  );

  always @(posedge mclk)
  begin
    if (rst)
      pls_d_reg <= {`SSIM_NSRC{1'b0}};
    else
      pls_d_reg <= pls_s;
  end

  // event bits: compares, syncs and the overrun load are rising edges
  always @*
  begin
    sticky_set = pls_s & ~pls_d_reg & `SSIM_STICKY_MASK;
  end

  // sticky event flags, cleared by a read of the status register
  ssim_sticky u_status
  (
    .mclk(mclk),
    .rst(rst),
    .set_evt(sticky_set),
    .clr(status_rd),
    .flag_reg(status_flags)
  );

  // the status view: level sources follow their inputs, events are sticky
  always @*
  begin
    status_view = (lvl_s & ~`SSIM_STICKY_MASK) | (status_flags & `SSIM_STICKY_MASK);
  end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write side

  reg aw_held_reg;
  reg w_held_reg;
  reg [`SSIM_ADDR_W-1:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire wr_fire;
  wire aw_take;
  wire w_take;
  wire b_take;
  wire wr_enable;
  wire wr_disable;
  wire wr_irq_mask;
  wire [`SSIM_SRC_MSB:0] wr_bits;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_take = s_axi_bvalid && s_axi_bready;
  // a write acts once, in the cycle both halves are held and no response is pending
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_enable = wr_fire && (awaddr_reg == `SSIM_OFF_ENABLE);
  assign wr_disable = wr_fire && (awaddr_reg == `SSIM_OFF_DISABLE);
  assign wr_irq_mask = wr_fire && (awaddr_reg == `SSIM_OFF_IRQ_MASK);
  // the low two lanes carry all twelve source bits; a missing lane leaves enable and disable alone but writes zeros to the irq mask
  assign wr_bits = wdata_reg[`SSIM_SRC_MSB:0]
    & {{`SSIM_LANE1_W{wstrb_reg[`SSIM_LANE1]}}, {`SSIM_LANE0_W{wstrb_reg[`SSIM_LANE0]}}};

  function addr_known;
    input [`SSIM_ADDR_W-1:0] a;
    begin
      addr_known = (a == `SSIM_OFF_STATUS) || (a == `SSIM_OFF_ENABLE)
        || (a == `SSIM_OFF_DISABLE) || (a == `SSIM_OFF_MASK)
        || (a == `SSIM_OFF_IRQ_STAT) || (a == `SSIM_OFF_IRQ_MASK);
    end
  endfunction

  // byte offsets below a word are ignored, so every register sits on an aligned word
  function [`SSIM_ADDR_W-1:0] word_addr;
    input [`SSIM_ADDR_W-1:0] a;
    begin
      word_addr = {a[`SSIM_ADDR_W-1:`SSIM_WORD_LSB], {`SSIM_WORD_LSB{1'b0}}};
    end
  endfunction

  always @(posedge mclk)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= {`SSIM_ADDR_W{1'b0}};
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSIM_RESP_OKAY;
    end
    else
    begin
      // readies stand high while idle, so a request is taken at its first edge
      s_axi_awready <= !aw_held_reg;
      s_axi_wready <= !w_held_reg;
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= word_addr(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(awaddr_reg) ? `SSIM_RESP_OKAY : `SSIM_RESP_SLVERR;
      end
      if (b_take)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// mask registers

  // one mask bit per source for the ssc line, set and cleared by position; the irq mask for the ctrl line is written whole
  always @*
  begin
    mask_next = mask_reg;
    ctl_mask_next = ctl_mask_reg;
    if (wr_enable)
      mask_next = mask_reg | wr_bits;
    else if (wr_disable)
      mask_next = mask_reg & ~wr_bits;
    else if (wr_irq_mask)
      ctl_mask_next = wr_bits;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      mask_reg <= `SSIM_MASK_RESET;
      ctl_mask_reg <= `SSIM_MASK_RESET;
    end
    else
    begin
      mask_reg <= mask_next;
      ctl_mask_reg <= ctl_mask_next;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// block-level interrupt status: rising edge of any status bit

  reg [`SSIM_SRC_MSB:0] view_d_reg;

  always @(posedge mclk)
  begin
    if (rst)
      view_d_reg <= {`SSIM_NSRC{1'b0}};
    else
      view_d_reg <= status_view;
  end

  always @*
  begin
    ctl_set = status_view & ~view_d_reg;
  end

  ssim_sticky u_ctl
  (
    .mclk(mclk),
    .rst(rst),
    .set_evt(ctl_set),
    .clr(ctl_rd),
    .flag_reg(ctl_flags)
  );

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read side

  wire rd_take;
  wire [`SSIM_ADDR_W-1:0] rd_word;
  reg [31:0] rd_value;
  reg [1:0] rd_resp;

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_word = word_addr(s_axi_araddr);

  always @*
  begin
    status_rd = rd_take && (rd_word == `SSIM_OFF_STATUS);
    ctl_rd = rd_take && (rd_word == `SSIM_OFF_IRQ_STAT);
  end

  // write-only registers fall through to zero with an okay response
  always @*
  begin
    rd_value = 32'h00000000;
    rd_resp = `SSIM_RESP_OKAY;
    if (rd_word == `SSIM_OFF_STATUS)
      rd_value = {{`SSIM_RSVD_W{1'b0}}, status_view};
    else if (rd_word == `SSIM_OFF_MASK)
      rd_value = {{`SSIM_RSVD_W{1'b0}}, mask_reg};
    else if (rd_word == `SSIM_OFF_IRQ_STAT)
      rd_value = {{`SSIM_RSVD_W{1'b0}}, ctl_flags};
    else if (rd_word == `SSIM_OFF_IRQ_MASK)
      rd_value = {{`SSIM_RSVD_W{1'b0}}, ctl_mask_reg};
    else if (!addr_known(rd_word))
      rd_resp = `SSIM_RESP_SLVERR;
  end

  // arready stays low while data waits, so one read at most is under way
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSIM_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid;
      if (rd_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_resp;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// interrupt outputs
// both lines sit one edge behind the flags and masks that they combine

  always @(posedge mclk)
  begin
    if (rst)
    begin
      ssc_irq_reg <= 1'b0;
      ctrl_irq_reg <= 1'b0;
    end
    else
    begin
      ssc_irq_reg <= |(status_view & mask_reg);
      ctrl_irq_reg <= |(ctl_flags & ctl_mask_reg);
    end
  end

endmodule
`default_nettype wire

// ---- sim/ssim_chk_asserts.sv ----
// concurrent checks on the ports of the interrupt mask block
`timescale 1ns/10ps
`default_nettype none
`include "ssim_map.vh"
module ssim_chk
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic ssc_irq_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // address of the read under way, so data can be judged by register
  logic [7:0] rd_addr;
  always_ff @(posedge mclk)
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  AST_RST_IDLE: assert property ($fell(rst) |-> !ssc_irq_reg && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  AST_WR_RESP: assert property (aw_take |-> ##[1:8] s_axi_bvalid)
    else $error("write got no response");
  AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_RSVD: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
    else $error("reserved bits not zero");
  AST_WO_ZERO: assert property (s_axi_rvalid && (rd_addr == `SSIM_OFF_ENABLE
    || rd_addr == `SSIM_OFF_DISABLE) |-> s_axi_rdata == 32'h00000000)
    else $error("write-only register read nonzero");
  AST_UNMAP: assert property (s_axi_rvalid && {rd_addr[7:2], 2'b00} > `SSIM_OFF_IRQ_MASK
    |-> s_axi_rresp == `SSIM_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule
bind ssim_top ssim_chk u_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ssc_irq_reg);
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the interrupt mask block
`timescale 1ns/10ps
`default_nettype none
`include "ssim_map.vh"
module testbench;
  localparam logic [7:0] ST = `SSIM_OFF_STATUS;
  localparam logic [7:0] EN = `SSIM_OFF_ENABLE;
  localparam logic [7:0] DI = `SSIM_OFF_DISABLE;
  localparam logic [7:0] MK = `SSIM_OFF_MASK;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [11:0] m;} ssim_row_t;
  // cumulative: each row's mask follows from all rows above it
  ssim_row_t rows [8] = '{'{EN, 32'h00000001, 12'h001}, '{EN, 32'h000000F0, 12'h0F1},
    '{DI, 32'h00000010, 12'h0E1}, '{EN, 32'hFFFFFFFF, 12'hFFF}, '{DI, 32'h00000040, 12'hFBF},
    '{DI, 32'h00000800, 12'h7BF}, '{EN, 32'h00000000, 12'h7BF}, '{DI, 32'h00000FFF, 12'h000}};
  int sb [5] = '{5, 8, 9, 10, 11};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, sirq, cirq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp, resp;
  logic [11:0] lvl, pls;
  integer err_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer i;
  ssim_top DUT (.mclk(mclk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .src_level(lvl), .src_pulse(pls), .ssc_irq_reg(sirq),
    .ctrl_irq_reg(cirq));
  always #4 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // bready and rready stand from the request on, so the answer is taken at its first edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = bresp;
    br <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    resp = rresp;
    rr <= 1'b0;
    chk(rd, e);
  endtask
  // events are held three cycles high and six low to cross the synchroniser
  task automatic pulse(input int b);
    @(posedge mclk);
    pls[b] <= 1'b1;
    repeat (3) @(posedge mclk);
    pls[b] <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {awv, wv, br, arv, rr, awa, ara, wd, lvl, pls} = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rc(MK, 32'h00000000);
    for (i = 0; i < 8; i++)
    begin
      bus_wr(rows[i].a, rows[i].d);
      rc(MK, {20'h00000, rows[i].m});
    end
    for (i = 0; i < 12; i++)
    begin
      bus_wr(EN, 32'h1 << i);
      rc(MK, 32'h1 << i);
      bus_wr(DI, 32'h1 << i);
    end
    rc(EN, 32'h00000000);
    bus_wr(8'h20, 32'h00000FFF);
    chk({30'h0, resp}, {30'h0, `SSIM_RESP_SLVERR});
    rc(8'h20, 32'h00000000);
    chk({30'h0, resp}, {30'h0, `SSIM_RESP_SLVERR});
    rc(MK, 32'h00000000);
    lvl <= 12'h040;
    repeat (6) @(posedge mclk);
    chk({31'h0, sirq}, 32'h0);
    rc(ST, 32'h00000040);
    bus_wr(EN, 32'h00000040);
    repeat (3) @(posedge mclk);
    chk({31'h0, sirq}, 32'h1);
    bus_wr(DI, 32'h00000040);
    repeat (3) @(posedge mclk);
    chk({31'h0, sirq}, 32'h0);
    lvl <= 12'h000;
    for (i = 0; i < 5; i++)
    begin
      bus_wr(EN, 32'h1 << sb[i]);
      pulse(sb[i]);
      chk({31'h0, sirq}, 32'h1);
      rc(ST, 32'h1 << sb[i]);
      rc(ST, 32'h00000000);
      chk({31'h0, sirq}, 32'h0);
      bus_wr(DI, 32'h1 << sb[i]);
    end
    pulse(8);
    chk({31'h0, sirq}, 32'h0);
    rc(ST, 32'h00000100);
    rc(`SSIM_OFF_IRQ_STAT, 32'h00000F60);
    bus_wr(`SSIM_OFF_IRQ_MASK, 32'h00000FFF);
    rc(`SSIM_OFF_IRQ_MASK, 32'h00000FFF);
    pulse(9);
    chk({31'h0, cirq}, 32'h1);
    rc(`SSIM_OFF_IRQ_STAT, 32'h00000200);
    @(posedge mclk);
    chk({31'h0, cirq}, 32'h0);
    bus_wr(EN, 32'h00000FFF);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rc(MK, 32'h00000000);
    wrap_up;
  end
endmodule
`default_nettype wire
